// ### hw/aux_regs_pkg.sv
// Shared constants and types of the radio auxiliary register bank
package aux_regs_pkg;
    // Register indices; the byte address is four times the index
    localparam int ADDR_WIDTH = 12;
    localparam int INDEX_WIDTH = 10;
    localparam logic [9:0] IDX_AUX_POWER_CONTROL = 10'h325;
    localparam logic [9:0] IDX_ADC_RESULT_UPPER = 10'h327;
    localparam logic [9:0] IDX_ADC_RESULT_LOWER = 10'h328;
    localparam logic [9:0] IDX_BATTERY_TRIP_LEVEL = 10'h32D;
    localparam logic [9:0] IDX_CLOCK_OUTPUT_DIVISOR = 10'h32E;
    localparam logic [9:0] IDX_GAIN_LOOP_RATE_DIVISOR = 10'h32F;
    localparam logic [9:0] IDX_EVENT_FLAGS_FIRST = 10'h336;
    localparam logic [9:0] IDX_EVENT_FLAGS_SECOND = 10'h337;
    localparam logic [9:0] IDX_CALIBRATION_ENABLES = 10'h338;
    localparam logic [9:0] IDX_CALIBRATION_PROGRESS = 10'h339;
    localparam logic [9:0] IDX_FILTER_CAL_WORD_RESULT = 10'h345;
    localparam logic [9:0] IDX_FILTER_CAL_WORD_OVERRIDE = 10'h346;
    // Field positions and widths
    localparam int ADC_WIDTH = 8;
    localparam int ADC_LOWER_LSB = 6;
    localparam int TRIP_CODE_WIDTH = 5;
    localparam int CLK_DIV_WIDTH = 4;
    localparam int GAIN_DIV_WIDTH = 8;
    localparam int GAIN_TICK_SHIFT = 4;
    localparam int BATT_ENABLE_BIT = 0;
    localparam int FLAG_WAKE_COUNT = 7;
    localparam int FLAG_WAKE_SIGNAL = 6;
    localparam int FLAG_CIPHER_DONE = 5;
    localparam int FLAG_TX_END = 4;
    localparam int FLAG_ADDRESS_MATCH = 3;
    localparam int FLAG_CHECKSUM_OK = 2;
    localparam int FLAG_SYNC_FOUND = 1;
    localparam int FLAG_PREAMBLE_FOUND = 0;
    localparam int FLAG_BATTERY_LOW = 7;
    localparam int FLAG_CMD_READY = 6;
    localparam int FLAG_WAKE_TIMER = 4;
    localparam int FLAG_HOST_PORT = 1;
    localparam int FLAG_CMD_FINISHED = 0;
    localparam logic [7:0] SECOND_USED_MASK = 8'hD3;
    localparam int CAL_SYNTH_BIT = 1;
    localparam int CAL_FILTER_BIT = 0;
    localparam int PA_RAMP_BIT = 2;
    localparam int CAL_WORD_WIDTH = 6;
    localparam int OVR_ENABLE_BIT = 0;
    localparam int OVR_WORD_LSB = 1;
    // Reset values
    localparam logic [3:0] RST_CLOCK_DIVISOR = 4'h4;
    localparam logic [7:0] RST_GAIN_DIVISOR = 8'h28;
    // Battery trip level: base 1700 mV, 62 mV per step
    localparam logic [11:0] TRIP_BASE_MV = 12'h6A4;
    localparam logic [11:0] TRIP_STEP_MV = 12'h03E;
    // Timing
    localparam int CORE_CLK_HZ = 25_000_000;
    localparam int SYNTH_CAL_TIME_US = 100;
    localparam int FILTER_CAL_TIME_US = 50;
    localparam int SYNTH_CAL_CYCLES = SYNTH_CAL_TIME_US * (CORE_CLK_HZ / 1_000_000);
    localparam int FILTER_CAL_CYCLES = FILTER_CAL_TIME_US * (CORE_CLK_HZ / 1_000_000);
    localparam int CAL_COUNT_WIDTH = 12;
    // Calibration sequencer states
    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_RUN = 3'b010,
        CAL_DONE = 3'b100
    } cal_state_type;
    // One-cycle event pulses from the radio core
    typedef struct packed {
        logic cipher_done;
        logic tx_end;
        logic address_match;
        logic checksum_ok;
        logic sync_found;
        logic preamble_found;
        logic cmd_ready;
        logic cmd_finished;
        logic wake_timer_expired;
        logic host_port_ready;
    } radio_events_type;
    // Operating conditions that qualify events
    typedef struct packed {
        logic packet_mode;
        logic cipher_loaded;
        logic smart_wake_active;
    } radio_mode_type;
endpackage

// ### hw/radio_aux_status_control_regs.sv
// Auxiliary status and control register bank of the radio, on APB
`timescale 1ns/1ps
`default_nettype none
module radio_aux_status_control_regs #(
    parameter int SYNTH_CAL_CYCLES = aux_regs_pkg::SYNTH_CAL_CYCLES,
    parameter int FILTER_CAL_CYCLES = aux_regs_pkg::FILTER_CAL_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [aux_regs_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter result
    input wire logic [7:0] adc_sample,
    input wire logic adc_sample_valid,
    // Battery supply measurement in millivolts
    input wire logic [11:0] supply_mv,
    // Wake-up counting and wake-mode signal strength
    input wire logic [15:0] wake_counter,
    input wire logic [15:0] wake_count_limit,
    input wire logic [7:0] wake_mode_signal_level,
    input wire logic [7:0] wake_mode_signal_limit,
    // Radio events and modes
    input wire aux_regs_pkg::radio_events_type radio_events,
    input wire aux_regs_pkg::radio_mode_type radio_mode,
    // Calibration inputs
    input wire logic [5:0] filter_cal_measured_word,
    input wire logic pa_ramp_finished,
    // Controls to the analog side
    output logic battery_monitor_enable,
    output logic [4:0] battery_trip_code,
    output logic shared_clock_output_pin,
    output logic gain_loop_tick,
    output logic synthesizer_cal_enable,
    output logic filter_cal_enable,
    output logic synthesizer_cal_done,
    output logic filter_cal_done,
    output logic [5:0] filter_cal_word
);
    logic [7:0] adc_upper_q;
    logic [7:0] adc_lower_q;
    logic battery_enable_q;
    logic [4:0] trip_code_q;
    logic [3:0] clock_divisor_q;
    logic [7:0] gain_divisor_q;
    logic [7:0] flags_first_q;
    logic [7:0] flags_first_d;
    logic [7:0] flags_second_q;
    logic [7:0] flags_second_d;
    logic synth_enable_q;
    logic filter_enable_q;
    logic [5:0] cal_word_q;
    logic [5:0] override_word_q;
    logic override_enable_q;
    logic wake_match_q;
    logic battery_low;
    logic wake_match;
    aux_regs_pkg::cal_state_type synth_state_q;
    aux_regs_pkg::cal_state_type filter_state_q;
    logic [11:0] synth_count_q;
    logic [11:0] filter_count_q;
    logic [7:0] set_first;
    logic [7:0] set_second;
    logic [9:0] index;
    logic aligned;
    logic mapped;
    logic access;
    logic write_en;
    logic [7:0] wbyte;
    logic [7:0] read_byte;
    logic [11:0] gain_divisor_wide;

    // Trip voltage for a code
    function automatic logic [11:0] trip_mv(input logic [4:0] code);
        trip_mv = aux_regs_pkg::TRIP_BASE_MV + 12'(code) * aux_regs_pkg::TRIP_STEP_MV;
    endfunction

    // Calibration sequencer step
    function automatic aux_regs_pkg::cal_state_type cal_next(
        input aux_regs_pkg::cal_state_type state,
        input logic enable,
        input logic count_done
    );
        cal_next = aux_regs_pkg::CAL_IDLE;
        if (enable) begin
            unique case (state)
                aux_regs_pkg::CAL_IDLE: cal_next = aux_regs_pkg::CAL_RUN;
                aux_regs_pkg::CAL_RUN: begin
                    cal_next = count_done ? aux_regs_pkg::CAL_DONE : aux_regs_pkg::CAL_RUN;
                end
                aux_regs_pkg::CAL_DONE: cal_next = aux_regs_pkg::CAL_DONE;
                default: cal_next = aux_regs_pkg::CAL_IDLE;
            endcase
        end
    endfunction

    // Bus decode
    assign index = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign access = psel && penable;
    assign wbyte = pwdata[7:0];
    always_comb begin
        mapped = aligned;
        unique case (index)
            aux_regs_pkg::IDX_AUX_POWER_CONTROL,
            aux_regs_pkg::IDX_ADC_RESULT_UPPER,
            aux_regs_pkg::IDX_ADC_RESULT_LOWER,
            aux_regs_pkg::IDX_BATTERY_TRIP_LEVEL,
            aux_regs_pkg::IDX_CLOCK_OUTPUT_DIVISOR,
            aux_regs_pkg::IDX_GAIN_LOOP_RATE_DIVISOR,
            aux_regs_pkg::IDX_EVENT_FLAGS_FIRST,
            aux_regs_pkg::IDX_EVENT_FLAGS_SECOND,
            aux_regs_pkg::IDX_CALIBRATION_ENABLES,
            aux_regs_pkg::IDX_CALIBRATION_PROGRESS,
            aux_regs_pkg::IDX_FILTER_CAL_WORD_RESULT,
            aux_regs_pkg::IDX_FILTER_CAL_WORD_OVERRIDE: mapped = aligned;
            default: mapped = 1'b0;
        endcase
    end
    assign write_en = access && pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // Read multiplexer
    always_comb begin
        read_byte = 8'h00;
        unique case (index)
            aux_regs_pkg::IDX_AUX_POWER_CONTROL: read_byte[aux_regs_pkg::BATT_ENABLE_BIT] = battery_enable_q;
            aux_regs_pkg::IDX_ADC_RESULT_UPPER: read_byte = adc_upper_q;
            aux_regs_pkg::IDX_ADC_RESULT_LOWER: read_byte = adc_lower_q;
            aux_regs_pkg::IDX_BATTERY_TRIP_LEVEL: read_byte = {3'h0, trip_code_q};
            aux_regs_pkg::IDX_CLOCK_OUTPUT_DIVISOR: read_byte = {4'h0, clock_divisor_q};
            aux_regs_pkg::IDX_GAIN_LOOP_RATE_DIVISOR: read_byte = gain_divisor_q;
            aux_regs_pkg::IDX_EVENT_FLAGS_FIRST: read_byte = flags_first_q;
            aux_regs_pkg::IDX_EVENT_FLAGS_SECOND: read_byte = flags_second_q;
            aux_regs_pkg::IDX_CALIBRATION_ENABLES: begin
                read_byte[aux_regs_pkg::CAL_SYNTH_BIT] = synth_enable_q;
                read_byte[aux_regs_pkg::CAL_FILTER_BIT] = filter_enable_q;
            end
            aux_regs_pkg::IDX_CALIBRATION_PROGRESS: begin
                read_byte[aux_regs_pkg::PA_RAMP_BIT] = pa_ramp_finished;
                read_byte[aux_regs_pkg::CAL_SYNTH_BIT] = synthesizer_cal_done;
                read_byte[aux_regs_pkg::CAL_FILTER_BIT] = filter_cal_done;
            end
            aux_regs_pkg::IDX_FILTER_CAL_WORD_RESULT: read_byte = {2'h0, cal_word_q};
            aux_regs_pkg::IDX_FILTER_CAL_WORD_OVERRIDE: begin
                read_byte = {1'b0, override_word_q, override_enable_q};
            end
            default: read_byte = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, aligned ? read_byte : 8'h00};
        end
    end

    // Converter result capture, both halves from one sample
    always_ff @(posedge core_clk) begin
        if (reset) begin
            adc_upper_q <= 8'h00;
            adc_lower_q <= 8'h00;
        end else if (adc_sample_valid) begin
            adc_upper_q <= {2'h0, adc_sample[7:2]};
            adc_lower_q <= {adc_sample[1:0], 6'h00};
        end
    end

    // Software controls
    always_ff @(posedge core_clk) begin
        if (reset) begin
            battery_enable_q <= 1'b0;
            trip_code_q <= 5'h00;
            clock_divisor_q <= aux_regs_pkg::RST_CLOCK_DIVISOR;
            gain_divisor_q <= aux_regs_pkg::RST_GAIN_DIVISOR;
            synth_enable_q <= 1'b0;
            filter_enable_q <= 1'b0;
            override_word_q <= 6'h00;
            override_enable_q <= 1'b0;
        end else if (write_en) begin
            unique case (index)
                aux_regs_pkg::IDX_AUX_POWER_CONTROL: begin
                    battery_enable_q <= wbyte[aux_regs_pkg::BATT_ENABLE_BIT];
                end
                aux_regs_pkg::IDX_BATTERY_TRIP_LEVEL: trip_code_q <= wbyte[4:0];
                aux_regs_pkg::IDX_CLOCK_OUTPUT_DIVISOR: clock_divisor_q <= wbyte[3:0];
                aux_regs_pkg::IDX_GAIN_LOOP_RATE_DIVISOR: gain_divisor_q <= wbyte;
                aux_regs_pkg::IDX_CALIBRATION_ENABLES: begin
                    synth_enable_q <= wbyte[aux_regs_pkg::CAL_SYNTH_BIT];
                    filter_enable_q <= wbyte[aux_regs_pkg::CAL_FILTER_BIT];
                end
                aux_regs_pkg::IDX_FILTER_CAL_WORD_OVERRIDE: begin
                    override_word_q <= wbyte[6:1];
                    override_enable_q <= wbyte[aux_regs_pkg::OVR_ENABLE_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Event detection
    assign battery_low = battery_enable_q && (supply_mv < trip_mv(trip_code_q));
    assign wake_match = (wake_counter == wake_count_limit);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wake_match_q <= 1'b0;
        end else begin
            wake_match_q <= wake_match;
        end
    end

    always_comb begin
        set_first = 8'h00;
        set_first[aux_regs_pkg::FLAG_WAKE_COUNT] = wake_match && !wake_match_q;
        set_first[aux_regs_pkg::FLAG_WAKE_SIGNAL] = radio_mode.smart_wake_active
            && (wake_mode_signal_level > wake_mode_signal_limit);
        set_first[aux_regs_pkg::FLAG_CIPHER_DONE] = radio_mode.cipher_loaded
            && radio_events.cipher_done;
        set_first[aux_regs_pkg::FLAG_TX_END] = radio_mode.packet_mode && radio_events.tx_end;
        set_first[aux_regs_pkg::FLAG_ADDRESS_MATCH] = radio_mode.packet_mode
            && radio_events.address_match;
        set_first[aux_regs_pkg::FLAG_CHECKSUM_OK] = radio_mode.packet_mode
            && radio_events.checksum_ok;
        set_first[aux_regs_pkg::FLAG_SYNC_FOUND] = radio_events.sync_found;
        set_first[aux_regs_pkg::FLAG_PREAMBLE_FOUND] = radio_events.preamble_found;
    end

    always_comb begin
        set_second = 8'h00;
        set_second[aux_regs_pkg::FLAG_BATTERY_LOW] = battery_low;
        set_second[aux_regs_pkg::FLAG_CMD_READY] = radio_events.cmd_ready;
        set_second[aux_regs_pkg::FLAG_CMD_FINISHED] = radio_events.cmd_finished;
        set_second[aux_regs_pkg::FLAG_WAKE_TIMER] = radio_events.wake_timer_expired;
        set_second[aux_regs_pkg::FLAG_HOST_PORT] = radio_events.host_port_ready;
    end

    // Sticky flags, write one to clear, a new event wins over the clear
    always_comb begin
        flags_first_d = flags_first_q;
        flags_second_d = flags_second_q;
        if (write_en && index == aux_regs_pkg::IDX_EVENT_FLAGS_FIRST) begin
            flags_first_d = flags_first_q & ~wbyte;
        end
        if (write_en && index == aux_regs_pkg::IDX_EVENT_FLAGS_SECOND) begin
            flags_second_d = flags_second_q & ~wbyte;
        end
        flags_first_d = flags_first_d | set_first;
        flags_second_d = (flags_second_d | set_second) & aux_regs_pkg::SECOND_USED_MASK;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            flags_first_q <= 8'h00;
            flags_second_q <= 8'h00;
        end else begin
            flags_first_q <= flags_first_d;
            flags_second_q <= flags_second_d;
        end
    end

    // Synthesizer calibration sequencer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            synth_state_q <= aux_regs_pkg::CAL_IDLE;
            synth_count_q <= 12'h000;
        end else begin
            synth_state_q <= cal_next(synth_state_q, synth_enable_q,
                synth_count_q == 12'(SYNTH_CAL_CYCLES - 1));
            if (synth_state_q == aux_regs_pkg::CAL_RUN) begin
                synth_count_q <= synth_count_q + 12'h001;
            end else begin
                synth_count_q <= 12'h000;
            end
        end
    end

    // Receive filter calibration sequencer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            filter_state_q <= aux_regs_pkg::CAL_IDLE;
            filter_count_q <= 12'h000;
        end else begin
            filter_state_q <= cal_next(filter_state_q, filter_enable_q,
                filter_count_q == 12'(FILTER_CAL_CYCLES - 1));
            if (filter_state_q == aux_regs_pkg::CAL_RUN) begin
                filter_count_q <= filter_count_q + 12'h001;
            end else begin
                filter_count_q <= 12'h000;
            end
        end
    end

    // Calibration word captured at the end of a filter calibration
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cal_word_q <= 6'h00;
        end else if (filter_state_q == aux_regs_pkg::CAL_RUN
            && filter_count_q == 12'(FILTER_CAL_CYCLES - 1)) begin
            cal_word_q <= filter_cal_measured_word;
        end
    end

    assign synthesizer_cal_done = (synth_state_q == aux_regs_pkg::CAL_DONE);
    assign filter_cal_done = (filter_state_q == aux_regs_pkg::CAL_DONE);
    assign synthesizer_cal_enable = synth_enable_q;
    assign filter_cal_enable = filter_enable_q;
    assign filter_cal_word = override_enable_q ? override_word_q : cal_word_q;
    assign battery_monitor_enable = battery_enable_q;
    assign battery_trip_code = trip_code_q;

    // Clock output and gain loop rate
    assign gain_divisor_wide = {gain_divisor_q, 4'h0};

    rate_divider #(
        .WIDTH(aux_regs_pkg::CLK_DIV_WIDTH)
    ) clock_output_divider (
        .core_clk(core_clk),
        .reset(reset),
        .divisor(clock_divisor_q),
        .level_out(shared_clock_output_pin),
        .tick()
    );

    rate_divider #(
        .WIDTH(aux_regs_pkg::GAIN_DIV_WIDTH + aux_regs_pkg::GAIN_TICK_SHIFT)
    ) gain_rate_divider (
        .core_clk(core_clk),
        .reset(reset),
        .divisor(gain_divisor_wide),
        .level_out(),
        .tick(gain_loop_tick)
    );
endmodule
`default_nettype wire

// ### hw/rate_divider.sv
// Programmable clock divider with level and tick outputs
`timescale 1ns/1ps
`default_nettype none
module rate_divider #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Division ratio, zero stops the outputs
    input wire logic [WIDTH-1:0] divisor,
    // Divided outputs
    output logic level_out,
    output logic tick
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    logic [WIDTH-1:0] half;
    logic running;
    logic wrap;

    assign running = (divisor != '0);
    assign half = divisor - (divisor >> 1);
    assign wrap = (count_q >= divisor - 1'b1);
    assign count_d = (!running || wrap) ? '0 : count_q + 1'b1;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            level_out <= 1'b0;
            tick <= 1'b0;
        end else begin
            level_out <= running && (count_d < half);
            tick <= running && wrap;
        end
    end
endmodule
`default_nettype wire

// ### test/aux_regs_checker.sv
// Port-level assertions for the auxiliary register bank
`timescale 1ns/1ps
`default_nettype none
module aux_regs_checker #(
    parameter int SYNTH_CAL_CYCLES = 4,
    parameter int FILTER_CAL_CYCLES = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Controls
    input wire logic battery_monitor_enable,
    input wire logic [4:0] battery_trip_code,
    input wire logic shared_clock_output_pin,
    input wire logic gain_loop_tick,
    input wire logic synthesizer_cal_enable,
    input wire logic filter_cal_enable,
    input wire logic synthesizer_cal_done,
    input wire logic filter_cal_done
);
    localparam int FIL_MAX = FILTER_CAL_CYCLES + 8;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_ready_always: assert property (pready) else $error("pready low");
    a_err_access_only: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
    a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error read not zero");
    a_trip_code_write: assert property (psel && penable && pwrite && paddr == 12'hCB4
        |=> {27'h0, battery_trip_code} == ($past(pwdata) & 32'h1F)) else $error("trip code not written");
    a_batt_en_write: assert property (psel && penable && pwrite && paddr == 12'hC94
        |=> {31'h0, battery_monitor_enable} == ($past(pwdata) & 32'h1)) else $error("monitor enable not written");
    a_synth_done_clear: assert property (!synthesizer_cal_enable |=> !synthesizer_cal_done)
        else $error("synth done without enable");
    a_filter_not_early: assert property ($rose(filter_cal_enable) |-> !filter_cal_done [*3])
        else $error("filter done too early");
    a_filter_done_bound: assert property ($rose(filter_cal_enable)
        |-> ##[1:FIL_MAX] (filter_cal_done || !filter_cal_enable)) else $error("filter cal too slow");
    a_tick_single: assert property (gain_loop_tick |=> !gain_loop_tick) else $error("tick too long");
endmodule
bind radio_aux_status_control_regs aux_regs_checker #(.SYNTH_CAL_CYCLES(SYNTH_CAL_CYCLES),
    .FILTER_CAL_CYCLES(FILTER_CAL_CYCLES)) chk_u (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .battery_monitor_enable(battery_monitor_enable), .battery_trip_code(battery_trip_code),
    .shared_clock_output_pin(shared_clock_output_pin), .gain_loop_tick(gain_loop_tick),
    .synthesizer_cal_enable(synthesizer_cal_enable), .filter_cal_enable(filter_cal_enable),
    .synthesizer_cal_done(synthesizer_cal_done), .filter_cal_done(filter_cal_done));
`default_nettype wire

// ### test/radio_aux_status_control_regs_tb_top.sv
// Self-checking testbench of the auxiliary register bank
`timescale 1ns/1ps
`default_nettype none
module radio_aux_status_control_regs_tb_top;
    logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, adc_valid = 0, ramp_done = 0;
    logic [11:0] paddr = 12'h0, supply_mv = 12'hFA0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, batt_en, clk_pin, tick, syn_en, fil_en, syn_done, fil_done;
    logic [7:0] adc = 8'h0, sig_level = 8'h0, sig_limit = 8'h8;
    logic [15:0] wake_count = 16'h0, wake_limit = 16'h5;
    logic [4:0] trip_code;
    logic [5:0] meas_word = 6'h2A, cal_word;
    aux_regs_pkg::radio_events_type events = '0;
    aux_regs_pkg::radio_mode_type mode = '0;
    int mismatches = 0, checked = 0;
    radio_aux_status_control_regs #(.SYNTH_CAL_CYCLES(4), .FILTER_CAL_CYCLES(4)) dut_u (
        .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_sample(adc),
        .adc_sample_valid(adc_valid), .supply_mv(supply_mv), .wake_counter(wake_count),
        .wake_count_limit(wake_limit), .wake_mode_signal_level(sig_level), .wake_mode_signal_limit(sig_limit),
        .radio_events(events), .radio_mode(mode), .filter_cal_measured_word(meas_word),
        .pa_ramp_finished(ramp_done), .battery_monitor_enable(batt_en), .battery_trip_code(trip_code),
        .shared_clock_output_pin(clk_pin), .gain_loop_tick(tick), .synthesizer_cal_enable(syn_en),
        .filter_cal_enable(fil_en), .synthesizer_cal_done(syn_done), .filter_cal_done(fil_done),
        .filter_cal_word(cal_word));
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    task automatic finish_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [9:0] ix, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            chk("pready", 32'h1, {31'h0, pready});
            finish_test();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [9:0] ix, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, ix, {24'h0, d}, r, e);
    endtask
    task automatic rd(input string nm, input logic [9:0] ix, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, ix, 32'h0, r, e);
        chk(nm, {24'h0, x}, r);
    endtask
    task automatic check_reset_values;
        rd("trip level", aux_regs_pkg::IDX_BATTERY_TRIP_LEVEL, 8'h00);
        rd("clock divisor", aux_regs_pkg::IDX_CLOCK_OUTPUT_DIVISOR, 8'h04);
        rd("gain divisor", aux_regs_pkg::IDX_GAIN_LOOP_RATE_DIVISOR, 8'h28);
        rd("first flags", aux_regs_pkg::IDX_EVENT_FLAGS_FIRST, 8'h00);
        rd("cal enables", aux_regs_pkg::IDX_CALIBRATION_ENABLES, 8'h00);
    endtask
    task automatic check_rates;
        logic [31:0] r;
        logic e;
        int n = 0, h = 0;
        repeat (1280) begin
            @(posedge core_clk);
            n += int'(tick === 1'b1);
        end
        chk("gain ticks", 32'd2, 32'(n));
        wr(aux_regs_pkg::IDX_CLOCK_OUTPUT_DIVISOR, 8'hF2);
        rd("clock divisor", aux_regs_pkg::IDX_CLOCK_OUTPUT_DIVISOR, 8'h02);
        repeat (8) begin
            @(posedge core_clk);
            h += int'(clk_pin === 1'b1);
        end
        chk("clock highs", 32'd4, 32'(h));
        wr(aux_regs_pkg::IDX_CLOCK_OUTPUT_DIVISOR, 8'h00);
        rd("clock divisor", aux_regs_pkg::IDX_CLOCK_OUTPUT_DIVISOR, 8'h00);
        chk("clock off", 32'h0, {31'h0, clk_pin});
        wr(aux_regs_pkg::IDX_CALIBRATION_PROGRESS, 8'hFF);
        rd("cal status", aux_regs_pkg::IDX_CALIBRATION_PROGRESS, 8'h00);
        apb(1'b0, 10'h300, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
    endtask
    task automatic check_adc;
        adc <= 8'hB5;
        adc_valid <= 1'b1;
        @(posedge core_clk);
        adc_valid <= 1'b0;
        rd("adc upper", aux_regs_pkg::IDX_ADC_RESULT_UPPER, 8'h2D);
        rd("adc lower", aux_regs_pkg::IDX_ADC_RESULT_LOWER, 8'h40);
    endtask
    task automatic pulse_events(input logic [2:0] m, input logic [7:0] f1, input logic [7:0] f2);
        mode <= aux_regs_pkg::radio_mode_type'(m);
        events <= '1;
        wake_count <= 16'h5;
        sig_level <= 8'h9;
        @(posedge core_clk);
        events <= '0;
        wake_count <= 16'h0;
        sig_level <= 8'h0;
        repeat (3) @(posedge core_clk);
        rd("first flags", aux_regs_pkg::IDX_EVENT_FLAGS_FIRST, f1);
        rd("second flags", aux_regs_pkg::IDX_EVENT_FLAGS_SECOND, f2);
        wr(aux_regs_pkg::IDX_EVENT_FLAGS_FIRST, 8'hFF);
        wr(aux_regs_pkg::IDX_EVENT_FLAGS_SECOND, 8'hFF);
        rd("first cleared", aux_regs_pkg::IDX_EVENT_FLAGS_FIRST, 8'h00);
    endtask
    task automatic check_battery;
        wr(aux_regs_pkg::IDX_BATTERY_TRIP_LEVEL, 8'h1F);
        supply_mv <= 12'hBB8;
        rd("battery off", aux_regs_pkg::IDX_EVENT_FLAGS_SECOND, 8'h00);
        wr(aux_regs_pkg::IDX_AUX_POWER_CONTROL, 8'h01);
        chk("monitor enable", 32'h1, {31'h0, batt_en});
        rd("battery low", aux_regs_pkg::IDX_EVENT_FLAGS_SECOND, 8'h80);
        supply_mv <= 12'hE26;
        wr(aux_regs_pkg::IDX_EVENT_FLAGS_SECOND, 8'h80);
        rd("battery at trip", aux_regs_pkg::IDX_EVENT_FLAGS_SECOND, 8'h00);
    endtask
    task automatic check_calibration;
        int n = 0;
        ramp_done <= 1'b1;
        wr(aux_regs_pkg::IDX_CALIBRATION_ENABLES, 8'hFF);
        while (!(syn_done === 1'b1 && fil_done === 1'b1) && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        chk("cal finished", 32'h1, {31'h0, n < 200});
        rd("cal status", aux_regs_pkg::IDX_CALIBRATION_PROGRESS, 8'h07);
        rd("cal word", aux_regs_pkg::IDX_FILTER_CAL_WORD_RESULT, 8'h2A);
        wr(aux_regs_pkg::IDX_FILTER_CAL_WORD_OVERRIDE, 8'hAB);
        rd("override", aux_regs_pkg::IDX_FILTER_CAL_WORD_OVERRIDE, 8'h2B);
        chk("cal word pin", 32'h15, {26'h0, cal_word});
        wr(aux_regs_pkg::IDX_CALIBRATION_ENABLES, 8'h00);
        rd("cal idle", aux_regs_pkg::IDX_CALIBRATION_PROGRESS, 8'h04);
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        check_reset_values();
        check_rates();
        check_adc();
        pulse_events(3'b111, 8'hFF, 8'h53);
        pulse_events(3'b100, 8'h9F, 8'h53);
        pulse_events(3'b010, 8'hA3, 8'h53);
        pulse_events(3'b001, 8'hC3, 8'h53);
        check_battery();
        check_calibration();
        finish_test();
    end
endmodule
`default_nettype wire
